// ### design/ocg_pkg.sv
// package: constants and types for the output clock gating block
package ocg_pkg;
    localparam int NUM_OUT        = 8;
    localparam int NUM_REF_PAIRS  = 6;
    localparam int CNT_W          = 8;
    localparam int DLY_W          = 16;
    localparam int EDGE_COUNT     = 2;
    localparam int PPS_TH_W       = 16;
    // apb register byte offsets
    localparam logic [7:0] ADDR_MODE_LO   = 8'h00;
    localparam logic [7:0] ADDR_MODE_HI   = 8'h04;
    localparam logic [7:0] ADDR_TRIG      = 8'h08;
    localparam logic [7:0] ADDR_STATUS    = 8'h0c;
    localparam logic [7:0] ADDR_PPS_TH    = 8'h10;
    localparam logic [7:0] ADDR_PPS_STAT  = 8'h14;
    localparam logic [7:0] ADDR_CNT_BASE  = 8'h20;
    localparam logic [7:0] ADDR_DLY_BASE  = 8'h40;
    // trigger register bit positions
    localparam int TRIG_REF_BIT   = 0;
    localparam int TRIG_SYNC_BIT  = 1;
    localparam int TRIG_RELOCK_BIT = 2;
    localparam logic [31:0] PPS_PERIOD_RESET = 32'h0ee6b280;
    localparam logic [31:0] RELOCK_LIMIT_RESET = 32'h1dcd6500;
    typedef enum logic [1:0]
    {
        OCG_MODE_PLAIN = 2'b00,
        OCG_MODE_REF   = 2'b01,
        OCG_MODE_PULSE = 2'b10,
        OCG_MODE_SYNC  = 2'b11
    } ocg_mode_t;
    typedef enum logic [1:0]
    {
        OCG_PPS_LOCKED = 2'b00,
        OCG_PPS_SNAP   = 2'b01,
        OCG_PPS_TUNE   = 2'b10
    } ocg_pps_t;
endpackage : ocg_pkg

// ### design/ocg_top.sv
// output clock gating: reference, pulser, delayed start and fast relock
// Summary of operation
// - eight outputs, each with its own programmable functional mode.
// - outputs zero to five may each be chosen as reference outputs.
// - reference outputs come from an internal clock pre-aligned to the device clock.
// - reference output is the internal clock gated glitch free by the trigger.
// - output starts after two internal clock falling edges following trigger rise.
// - output stops after two internal clock falling edges following trigger fall.
// - pulser mode emits the per-output 8-bit count of pulses, 1 to 255.
// - pulser mode takes trigger from pin or register write.
// - delayed start emits first edge after programmed oscillator-period delay.
// - delayed start output stops glitch free two falling edges after trigger low.
// - delayed start trigger comes from pin or register write.
// - one pulse per second output relocks within two seconds on phase jump.
// - high-frequency output holds phase during snap, released after a single one-cycle tune state.
// - relock triggers by threshold detection, pin, or register write.
`timescale 1ns/10ps
module ocg_top
    import ocg_pkg::*;
#(
    parameter int          NOUT        = ocg_pkg::NUM_OUT,
    parameter logic [31:0] PPS_PERIOD  = ocg_pkg::PPS_PERIOD_RESET,
    parameter logic [31:0] RELOCK_LIM  = ocg_pkg::RELOCK_LIMIT_RESET
)
(
    // apb
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // clocks and pins, sampled synchronously to pclk
    input  wire logic              pll_oscillator_clk,
    input  wire logic [NOUT-1:0]   div_clk,
    input  wire logic              ref_trig_pin,
    input  wire logic              sync_trig_pin,
    input  wire logic              relock_trig_pin,
    input  wire logic              one_pulse_per_second_in,
    input  wire logic [15:0]       pps_phase_err,
    // outputs
    output logic      [NOUT-1:0]   clk_out,
    output logic                   one_pulse_per_second_out,
    output logic                   hf_phase_hold
);
    import ocg_pkg::*;

    function automatic logic [31:0] apb_sel(input logic [7:0] a, input logic [7:0] b);
        apb_sel = (a == b) ? 32'h0000_0001 : 32'h0000_0000;
    endfunction : apb_sel

    // registers
    logic [2*NOUT-1:0]  mode_q,    mode_d;
    logic [2:0]         trig_q,    trig_d;
    logic [CNT_W-1:0]   cnt_q [NOUT];
    logic [CNT_W-1:0]   cnt_d [NOUT];
    logic [DLY_W-1:0]   dly_q [NOUT];
    logic [DLY_W-1:0]   dly_d [NOUT];
    logic [PPS_TH_W-1:0] th_q,     th_d;
    logic [31:0]        prdata_q,  prdata_d;
    logic               pslverr_q, pslverr_d;
    logic               pready_q,  pready_d;

    logic               acc;
    logic [NOUT-1:0]    active;
    logic [1:0]         pps_state;

    assign acc = psel && penable && !pready_q;

    always_comb
    begin
        mode_d    = mode_q;
        trig_d    = trig_q;
        th_d      = th_q;
        cnt_d     = cnt_q;
        dly_d     = dly_q;
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        pready_d  = acc;
        if (acc)
        begin
            pslverr_d = 1'b0;
            prdata_d  = 32'h0000_0000;
            if (paddr == ADDR_MODE_LO)
            begin
                if (pwrite) mode_d[7:0] = pwdata[7:0];
                prdata_d = {24'h000000, mode_q[7:0]};
            end
            else if (paddr == ADDR_MODE_HI)
            begin
                if (pwrite) mode_d[2*NOUT-1:8] = pwdata[2*NOUT-9:0];
                prdata_d = {{(40-2*NOUT){1'b0}}, mode_q[2*NOUT-1:8]};
            end
            else if (paddr == ADDR_TRIG)
            begin
                if (pwrite) trig_d = pwdata[2:0];
                prdata_d = {29'h0, trig_q};
            end
            else if (paddr == ADDR_STATUS)
                prdata_d = {{(32-NOUT){1'b0}}, active};
            else if (paddr == ADDR_PPS_TH)
            begin
                if (pwrite) th_d = pwdata[PPS_TH_W-1:0];
                prdata_d = {16'h0000, th_q};
            end
            else if (paddr == ADDR_PPS_STAT)
                prdata_d = {29'h0, hf_phase_hold, pps_state};
            else if (paddr >= ADDR_CNT_BASE && paddr < ADDR_CNT_BASE + 8'(4*NOUT))
            begin
                if (pwrite) cnt_d[paddr[4:2]] = pwdata[CNT_W-1:0];
                prdata_d = {24'h000000, cnt_q[paddr[4:2]]};
            end
            else if (paddr >= ADDR_DLY_BASE && paddr < ADDR_DLY_BASE + 8'(4*NOUT))
            begin
                if (pwrite) dly_d[paddr[4:2]] = pwdata[DLY_W-1:0];
                prdata_d = {16'h0000, dly_q[paddr[4:2]]};
            end
            else
                pslverr_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q    <= '0;
            trig_q    <= '0;
            th_q      <= '0;
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
            pready_q  <= 1'b0;
            for (int i = 0; i < NOUT; i++)
            begin
                cnt_q[i] <= 8'h01;
                dly_q[i] <= '0;
            end
        end
        else
        begin
            mode_q    <= mode_d;
            trig_q    <= trig_d;
            th_q      <= th_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
            pready_q  <= pready_d;
            cnt_q     <= cnt_d;
            dly_q     <= dly_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // combined triggers, two-flop synchronisers
    logic [2:0] trig_raw, sync1_q, sync2_q;
    assign trig_raw = {relock_trig_pin | trig_q[TRIG_RELOCK_BIT],
                       sync_trig_pin   | trig_q[TRIG_SYNC_BIT],
                       ref_trig_pin    | trig_q[TRIG_REF_BIT]};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= trig_raw;
            sync2_q <= sync1_q;
        end
    end

    // per-output gating; divided clocks are sampled by pclk
    logic [NOUT-1:0] prev_q, out_q;
    logic [NOUT-1:0] prev_d, out_d;
    genvar g;
    generate
        for (g = 0; g < NOUT; g++)
        begin : g_out
            logic [1:0]        ne_q,  ne_d;
            logic              en_q,  en_d;
            logic [CNT_W-1:0]  pc_q,  pc_d;
            logic [DLY_W-1:0]  dc_q,  dc_d;
            logic              dgo_q, dgo_d;
            logic              osc_q;
            logic [1:0]        md;
            logic              trg, fall, rise;
            assign md   = (g < NUM_REF_PAIRS || mode_q[2*g +: 2] == OCG_MODE_SYNC
                           || mode_q[2*g +: 2] == OCG_MODE_PLAIN)
                          ? mode_q[2*g +: 2] : OCG_MODE_PLAIN;
            assign trg  = (md == OCG_MODE_SYNC) ? sync2_q[TRIG_SYNC_BIT]
                                                 : sync2_q[TRIG_REF_BIT];
            assign fall = prev_q[g] && !div_clk[g];
            assign rise = !prev_q[g] && div_clk[g];
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn) osc_q <= 1'b0;
                else          osc_q <= pll_oscillator_clk;
            end
            always_comb
            begin
                ne_d  = ne_q;
                en_d  = en_q;
                pc_d  = pc_q;
                dc_d  = dc_q;
                dgo_d = dgo_q;
                if (md == OCG_MODE_PLAIN)
                begin
                    en_d = 1'b1;
                    ne_d = 2'd0;
                end
                else if (md == OCG_MODE_SYNC && trg && !dgo_q)
                begin
                    // delay counted in oscillator rising edges seen by pclk
                    if (osc_q != pll_oscillator_clk && pll_oscillator_clk)
                        dc_d = dc_q + 16'h0001;
                    if (dc_q >= dly_q[g])
                    begin
                        dgo_d = 1'b1;
                        en_d  = 1'b1;
                    end
                end
                else if (trg != en_q && fall && !(md == OCG_MODE_PULSE && dgo_q))
                begin
                    // switch only at falling edges so no runt pulse escapes
                    ne_d = ne_q + 2'd1;
                    if (ne_q + 2'd1 == 2'(EDGE_COUNT))
                    begin
                        en_d = trg && !(md == OCG_MODE_PULSE && cnt_q[g] == '0);
                        ne_d = 2'd0;
                        pc_d = cnt_q[g];
                        dgo_d = (md == OCG_MODE_PULSE) && trg; // one burst per trigger
                    end
                end
                else if (trg == en_q)
                    ne_d = 2'd0;
                if (md == OCG_MODE_PULSE && en_q && fall && pc_q != 8'h00)
                begin
                    pc_d = pc_q - 8'h01;
                    if (pc_q == 8'h01) en_d = 1'b0;
                end
                if (md == OCG_MODE_PULSE && !trg && pc_q == 8'h00)
                    en_d = 1'b0;
                if (!trg)
                begin
                    dgo_d = 1'b0;
                    dc_d  = '0;
                end
            end
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    ne_q  <= '0;
                    en_q  <= 1'b0;
                    pc_q  <= '0;
                    dc_q  <= '0;
                    dgo_q <= 1'b0;
                end
                else
                begin
                    ne_q  <= ne_d;
                    en_q  <= en_d;
                    pc_q  <= pc_d;
                    dc_q  <= dc_d;
                    dgo_q <= dgo_d;
                end
            end
            assign prev_d[g] = div_clk[g];
            assign out_d[g]  = en_q ? div_clk[g] : 1'b0;
            assign active[g] = en_q;
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_q <= '0;
            out_q  <= '0;
        end
        else
        begin
            prev_q <= prev_d;
            out_q  <= out_d;
        end
    end
    assign clk_out = out_q;

    // fast relock of the one pulse per second loop
    ocg_pps_t   st_q, st_d;
    logic [31:0] ph_q, ph_d, rl_q, rl_d;
    logic        pps_prev_q, pout_q, pout_d, hold_q, hold_d;
    logic        pps_rise, jump;
    assign pps_rise = one_pulse_per_second_in && !pps_prev_q;
    assign jump = (pps_phase_err[15] ? (16'(-pps_phase_err) >= th_q)
                                     : (pps_phase_err >= th_q)) && th_q != 16'h0000;
    always_comb
    begin
        st_d   = st_q;
        ph_d   = (ph_q + 32'h1 >= PPS_PERIOD) ? 32'h0 : ph_q + 32'h1;
        rl_d   = rl_q;
        pout_d = (ph_q < (PPS_PERIOD >> 1));
        hold_d = hold_q;
        case (st_q)
            OCG_PPS_LOCKED:
            begin
                hold_d = 1'b0;
                if (jump || sync2_q[TRIG_RELOCK_BIT])
                begin
                    st_d   = OCG_PPS_SNAP;
                    rl_d   = '0;
                    hold_d = 1'b1;
                end
            end
            OCG_PPS_SNAP:
            begin
                rl_d = rl_q + 32'h1;
                if (pps_rise || rl_q >= RELOCK_LIM)
                begin
                    ph_d = '0;
                    st_d = OCG_PPS_TUNE;
                end
            end
            OCG_PPS_TUNE:
            begin
                hold_d = 1'b0;
                st_d   = OCG_PPS_LOCKED;
            end
            default: st_d = OCG_PPS_LOCKED;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q       <= OCG_PPS_LOCKED;
            ph_q       <= '0;
            rl_q       <= '0;
            pps_prev_q <= 1'b0;
            pout_q     <= 1'b0;
            hold_q     <= 1'b0;
        end
        else
        begin
            st_q       <= st_d;
            ph_q       <= ph_d;
            rl_q       <= rl_d;
            pps_prev_q <= one_pulse_per_second_in;
            pout_q     <= pout_d;
            hold_q     <= hold_d;
        end
    end
    assign pps_state = st_q;
    assign one_pulse_per_second_out = pout_q;
    assign hf_phase_hold = hold_q;
endmodule : ocg_top

// ### test/ocg_checker.sv
// checker: apb handshake and output gating assertions
`timescale 1ns/10ps
module ocg_checker #(parameter int NOUT = 8)
(
    // clock and reset
    input wire logic            pclk,
    input wire logic            presetn,
    // apb
    input wire logic            psel,
    input wire logic            penable,
    input wire logic [7:0]      paddr,
    input wire logic            pready,
    input wire logic            pslverr,
    // clocks
    input wire logic [NOUT-1:0] div_clk,
    input wire logic [NOUT-1:0] clk_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic hole;
    assign hole = (paddr == 8'h18) || (paddr == 8'h1c) || (paddr >= 8'h60);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_rise0;
        $rose(clk_out[0]);
    endsequence
    property p_one_wait;
        s_access |=> pready;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("pready late");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
    property p_ready_access;
        pready |-> psel && penable;
    endproperty
    a_ready_access: assert property (p_ready_access) else $error("stray pready");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("stray error");
    property p_hole_err;
        pready && hole |-> pslverr;
    endproperty
    a_hole_err: assert property (p_hole_err) else $error("hole not refused");
    property p_map_ok;
        pready && !hole && (paddr[1:0] == 2'b00) |-> !pslverr;
    endproperty
    a_map_ok: assert property (p_map_ok) else $error("mapped refused");
    // gated output may only rise on a recent source high
    property p_src_edge;
        s_rise0 |-> $past(div_clk[0], 1) || $past(div_clk[0], 2) || $past(div_clk[0], 3);
    endproperty
    a_src_edge: assert property (p_src_edge) else $error("edge without source");
    property p_no_glitch;
        s_rise0 |-> clk_out[0] [*2];
    endproperty
    a_no_glitch: assert property (p_no_glitch) else $error("runt pulse");
endmodule : ocg_checker
bind ocg_top ocg_checker #(.NOUT(NOUT)) u_chk
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .div_clk(div_clk), .clk_out(clk_out)
);

// ### test/ocg_partner.sv
// partner: converter side counting pulses on each output clock
`timescale 1ns/10ps
module ocg_partner #(parameter int NOUT = 8)
(
    // clock and control
    input wire logic            pclk,
    input wire logic            clr,
    // clocks from the device
    input wire logic [NOUT-1:0] clk_out,
    // pulses seen per output
    output logic     [15:0]     edge_cnt [NOUT]
);
    logic [NOUT-1:0] last_q;
    // sampled at pclk since the outputs are registered there
    always_ff @(posedge pclk)
    begin
        last_q <= clk_out;
        for (int i = 0; i < NOUT; i++)
        begin
            if (clr)
                edge_cnt[i] <= 16'h0;
            else if (clk_out[i] && !last_q[i])
                edge_cnt[i] <= edge_cnt[i] + 16'h1;
        end
    end
endmodule : ocg_partner

// ### test/output_clock_gating_modes_tb_top.sv
// testbench: register access, gating modes and fast relock
`timescale 1ns/10ps
module output_clock_gating_modes_tb_top;
    import ocg_pkg::*;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        osc     = 1'b0;
    logic        pps     = 1'b0;
    logic        clr     = 1'b1;
    logic [7:0]  div     = 8'h00;
    logic        ref_pin = 1'b0;
    logic        syn_pin = 1'b0;
    logic        rlk_pin = 1'b0;
    logic [15:0] perr    = 16'h0000;
    logic [7:0]  clk_out;
    logic        pps_out;
    logic        hold;
    logic [15:0] cnt [8];
    logic [31:0] rd;
    logic        err;
    int          n_fail = 0;
    int          check_count = 0;
    int          cyc = 0;

    ocg_top #(.PPS_PERIOD(32'h64), .RELOCK_LIM(32'hc8)) dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pll_oscillator_clk(osc),
        .div_clk(div), .ref_trig_pin(ref_pin), .sync_trig_pin(syn_pin),
        .relock_trig_pin(rlk_pin), .one_pulse_per_second_in(pps),
        .pps_phase_err(perr), .clk_out(clk_out),
        .one_pulse_per_second_out(pps_out), .hf_phase_hold(hold)
    );
    ocg_partner #(.NOUT(8)) u_conv (.pclk(pclk), .clr(clr), .clk_out(clk_out), .edge_cnt(cnt));

    always #2 pclk = ~pclk;

    // sources: oscillator 2 cycles, output clocks 8 cycles, pps every 100
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        osc <= ~osc;
        pps <= (cyc % 100 == 0);
        if (cyc % 4 == 3)
            div <= ~div;
        if (cyc == 5000)
        begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20)
            n_fail++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        check(rd, e);
    endtask : rchk

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt

    task automatic clear_cnt;
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        @(posedge pclk);
    endtask : clear_cnt

    // sources 0 ref pin, 1 ref register, 2 delayed pin, 3 delayed register
    task automatic trig(input int s, input logic v);
        case (s)
            0: ref_pin <= v;
            1: xfer(ADDR_TRIG, 1'b1, {31'h0, v});
            2: syn_pin <= v;
            default: xfer(ADDR_TRIG, 1'b1, {30'h0, v, 1'b0});
        endcase
    endtask : trig

    // relock aligned just after an input pulse so snap cannot end early
    task automatic after_pps;
        do
            @(posedge pclk);
        while (pps !== 1'b1);
    endtask : after_pps

    task automatic print_verdict;
        if (n_fail == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    initial
    begin
        int o;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        clr <= 1'b0;
        rchk(ADDR_MODE_LO, 32'h0);
        rchk(ADDR_CNT_BASE + 8'h04, 32'h1);
        rchk(ADDR_TRIG, 32'h0);
        xfer(8'h18, 1'b1, 32'h5);
        check({31'h0, err}, 32'h1);
        xfer(ADDR_MODE_LO, 1'b1, 32'h39);
        rchk(ADDR_MODE_LO, 32'h39);
        xfer(ADDR_MODE_HI, 1'b1, 32'h10);
        xfer(ADDR_CNT_BASE, 1'b1, 32'hff);
        rchk(ADDR_CNT_BASE, 32'hff);
        xfer(ADDR_CNT_BASE + 8'h04, 1'b1, 32'h3);
        xfer(ADDR_DLY_BASE + 8'h08, 1'b1, 32'h4);
        for (int s = 0; s < 4; s++)
        begin
            o = (s < 2) ? 0 : 2;
            wt(40);                                         // low five periods
            clear_cnt();
            wt(16);
            check({16'h0, cnt[o]}, 32'h0);
            check({31'h0, cnt[6] != 16'h0}, 32'h1);
            trig(s, 1'b1);
            wt(4);
            check({16'h0, cnt[o]}, 32'h0);
            wt(80);                                         // high long enough
            check({31'h0, cnt[o] != 16'h0}, 32'h1);
            check({16'h0, cnt[1]}, (s < 2) ? 32'h3 : 32'h0);
            check({16'h0, cnt[2 - o]}, 32'h0);
            check({31'h0, cnt[3] != 16'h0}, 32'h1);
            trig(s, 1'b0);
        end
        after_pps();
        xfer(ADDR_TRIG, 1'b1, 32'h4);
        rchk(ADDR_PPS_STAT, 32'h5);
        check({31'h0, hold}, 32'h1);
        xfer(ADDR_TRIG, 1'b1, 32'h0);
        wt(250);
        check({31'h0, hold}, 32'h0);
        after_pps();
        rlk_pin <= 1'b1;
        wt(4);
        rlk_pin <= 1'b0;
        wt(4);
        check({31'h0, hold}, 32'h1);
        wt(250);
        check({31'h0, hold}, 32'h0);
        xfer(ADDR_PPS_TH, 1'b1, 32'h100);
        rchk(ADDR_PPS_TH, 32'h100);
        after_pps();
        perr <= 16'hfe00;
        wt(4);
        check({31'h0, hold}, 32'h1);
        perr <= 16'h0000;
        wt(250);
        check({31'h0, hold}, 32'h0);
        after_pps();
        wt(10);
        check({31'h0, pps_out}, 32'h1);
        wt(50);
        check({31'h0, pps_out}, 32'h0);
        print_verdict();
    end
endmodule : output_clock_gating_modes_tb_top
